// >>> rtl/mtc_mac_timer.sv
// MAC timer core: up-counter with period overflow, byte compare, SFD capture,
// 20-bit overflow count with compare, and sleep-clock synchronised start/stop.
// Assumes sys_clk as only clock, synchronous inputs other than sleep_clk, mtc_pkg compiled first.
//
// Functional notes
// [R1] Compare event when next byte >= compare value
// [R2] Select bit picks high or low timer byte
// [R3] Compare sets flag; irq only if masked in
// [R4] Capture on SFD status rising edge
// [R5] Capture timer and overflow count together
// [R6] Overflow count increments by one per overflow
// [R7] Low byte read latches upper count bytes
// [R8] Count writable while idle or running
// [R9] Lower bytes staged, applied on high write
// [R10] Match event when count >= overflow compare
// [R11] Match sets flag; irq only if masked in
// [R12] Flags set by hardware, cleared by software
// [R13] DMA pulses on compare and on overflow
// [R14] Sleep clock edge resynchronised to system clock
// [R15] Sync stop: halt on edge, store sleep value
// [R16] Sync start: wait edge, reload after 75 cycles
// [R17] System must use full-rate clock for sync
// [R18] Elapsed sleep count wraps by two to 24
// [R19] Total = elapsed*976.5625 + timer + 75, rounded
// [R20] New timer = total mod period; count adds quotient
// [R21] Reloaded timer may be off by one count
// [R22] Software bounds the stopped interval length
// [R23] Overflow reloads next value minus period
// [R24] Select 0 is bits 15:8, 1 is 7:0
// [R25] Run readback changes only on actual start/stop
// [R26] Events and DMA triggers are one-cycle pulses
//
// Chosen here: the register offsets and strobed register access.
`include "mtc_regs.svh"
`default_nettype none

module mtc_mac_timer (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire mtc_pkg::mtc_bus_req_t bus_req,
  output logic [7:0] rd_data,
  input wire logic sfd_status,
  input wire logic sleep_clk,
  input wire logic [23:0] sleep_count,
  output var mtc_pkg::mtc_event_t irq_req,
  output logic dma_trig_compare,
  output logic dma_trig_overflow,
  output logic timer_running
);
  import mtc_pkg::*;

  // ==========================================================
  // Decoding helpers
  function automatic logic [7:0] pick_byte(input logic [15:0] v, input logic lo_sel);
    return lo_sel ? v[7:0] : v[15:8];
  endfunction : pick_byte

  function automatic logic wr_at(input mtc_bus_req_t r, input logic [3:0] a);
    return r.wr && (r.addr == a);
  endfunction : wr_at

  // ==========================================================
  // State
  mtc_state_t state_q;
  logic [15:0] timer_q;
  logic [15:0] period_q;
  logic [15:0] capture_q;
  logic [19:0] ovf_cnt_q;
  logic [19:0] ovf_cmp_q;
  logic [19:0] ovf_cap_q;
  logic [7:0] cmp_val_q;
  logic [7:0] ovf_stage_lo_q;
  logic [7:0] ovf_stage_mid_q;
  logic [7:0] ovf_rd_mid_q;
  logic [3:0] ovf_rd_hi_q;
  logic sel_lo_q;
  logic sync_en_q;
  mtc_event_t mask_q;
  mtc_event_t flag_q;
  logic cmp_prev_q;
  logic match_prev_q;
  logic sfd_prev_q;
  logic slp_meta_q;
  logic slp_sync_q;
  logic slp_prev_q;
  logic [23:0] stored_sleep_q;
  logic [39:0] div_dvd_q;
  logic [15:0] div_rem_q;
  logic [5:0] div_step_q;
  logic [6:0] sync_cyc_q;

  // ==========================================================
  // Combinational events
  logic counting;
  logic [16:0] next_cnt;
  logic ovf_hit;
  logic cmp_cond;
  logic match_cond;
  logic sfd_rise;
  logic slp_edge;
  logic cfg_wr;
  logic run_val;
  logic calc_done;
  mtc_event_t ev;

  assign counting = (state_q == ST_RUN) || (state_q == ST_STOP_WAIT);
  assign next_cnt = {1'b0, timer_q} + 17'h00001;
  assign ovf_hit = counting && (next_cnt >= {1'b0, period_q}); // R23
  assign cmp_cond = counting && (pick_byte(next_cnt[15:0], sel_lo_q) >= cmp_val_q); // R1 R2 R24
  assign match_cond = ovf_cnt_q >= ovf_cmp_q; // R10
  assign sfd_rise = sfd_status && !sfd_prev_q; // R4
  assign slp_edge = slp_sync_q && !slp_prev_q; // R14
  assign cfg_wr = wr_at(bus_req, `MTC_ADDR_CFG);
  assign run_val = bus_req.wdata[`MTC_CFG_RUN];
  assign calc_done = (state_q == ST_CALC) && (sync_cyc_q == `MTC_SYNC_OVERHEAD - 7'd1); // R16

  // Compare and match levels become single-cycle events on their rising edge; overflow passes through as ovf_hit
  assign ev.cmp = cmp_cond && !cmp_prev_q; // R26
  assign ev.ovf = ovf_hit; // R26
  assign ev.ovf_match = match_cond && !match_prev_q; // R26

  // ==========================================================
  // Resync arithmetic
  logic [23:0] sleep_diff;
  logic [24:0] sleep_elapsed;
  logic [39:0] scaled;
  logic [39:0] total_cnt;
  logic [16:0] rem_shift;
  logic rem_ge;

  assign sleep_diff = sleep_count - stored_sleep_q;
  assign sleep_elapsed = (sleep_diff == 24'h000000) ? `MTC_SLEEP_WRAP : {1'b0, sleep_diff}; // R18
  assign scaled = 40'(sleep_elapsed) * `MTC_RATIO_NUM; // R19
  // Half-count bias gives round to nearest; residual phase error stays within one count
  assign total_cnt = ((scaled + `MTC_ROUND_HALF) >> `MTC_RATIO_SHIFT) + 40'(timer_q)
                     + 40'(`MTC_SYNC_OVERHEAD); // R19 R21
  assign rem_shift = {div_rem_q, div_dvd_q[39]};
  assign rem_ge = rem_shift >= {1'b0, period_q};

  // ==========================================================
  // Input synchronisers and edge history
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      slp_meta_q <= 1'b0;
      slp_sync_q <= 1'b0;
      slp_prev_q <= 1'b0;
      sfd_prev_q <= 1'b0;
      cmp_prev_q <= 1'b0;
      match_prev_q <= 1'b0;
    end else begin
      slp_meta_q <= sleep_clk; // R14
      slp_sync_q <= slp_meta_q; // R14
      slp_prev_q <= slp_sync_q;
      sfd_prev_q <= sfd_status;
      cmp_prev_q <= cmp_cond;
      match_prev_q <= match_cond;
    end
  end

  // ==========================================================
  // Run state machine
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (cfg_wr && run_val) begin
            state_q <= bus_req.wdata[`MTC_CFG_SYNC] ? ST_START_WAIT : ST_RUN; // R16
          end
        end
        ST_START_WAIT: begin
          if (cfg_wr && !run_val) begin
            state_q <= ST_IDLE;
          end else if (slp_edge) begin
            state_q <= ST_CALC; // R16
          end
        end
        ST_CALC: begin
          if (calc_done) begin
            state_q <= ST_RUN; // R16
          end
        end
        ST_RUN: begin
          if (cfg_wr && !run_val) begin
            state_q <= bus_req.wdata[`MTC_CFG_SYNC] ? ST_STOP_WAIT : ST_IDLE; // R15
          end
        end
        ST_STOP_WAIT: begin
          if (cfg_wr && run_val) begin
            state_q <= ST_RUN;
          end else if (slp_edge) begin
            state_q <= ST_IDLE; // R15
          end
        end
      endcase
    end
  end

  // Sleep value stored at the synchronous stop
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      stored_sleep_q <= 24'h000000;
    end else if ((state_q == ST_STOP_WAIT) && !(cfg_wr && run_val) && slp_edge) begin
      stored_sleep_q <= sleep_count; // R15
    end
  end

  // ==========================================================
  // Reload divider: total / period over 40 steps, well inside 75 cycles
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_dvd_q <= 40'h0000000000;
      div_rem_q <= 16'h0000;
      div_step_q <= 6'h00;
      sync_cyc_q <= 7'h00;
    end else if ((state_q == ST_START_WAIT) && !(cfg_wr && !run_val) && slp_edge) begin
      div_dvd_q <= total_cnt;
      div_rem_q <= 16'h0000;
      div_step_q <= 6'h00;
      sync_cyc_q <= 7'h01;
    end else if (state_q == ST_CALC) begin
      sync_cyc_q <= sync_cyc_q + 7'h01;
      if (div_step_q < `MTC_DIV_STEPS) begin
        div_dvd_q <= {div_dvd_q[38:0], rem_ge}; // R20
        div_rem_q <= rem_ge ? 16'(rem_shift - {1'b0, period_q}) : rem_shift[15:0]; // R20
        div_step_q <= div_step_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // Timer counter
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      timer_q <= 16'h0000;
    end else if (calc_done) begin
      timer_q <= div_rem_q; // R20
    end else if (counting) begin
      timer_q <= ovf_hit ? 16'(next_cnt - {1'b0, period_q}) : next_cnt[15:0]; // R23
    end
  end

  // ==========================================================
  // Overflow count with staged write and latched read
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ovf_cnt_q <= 20'h00000;
    end else if (wr_at(bus_req, `MTC_ADDR_OVF_HI)) begin
      ovf_cnt_q <= {bus_req.wdata[3:0], ovf_stage_mid_q, ovf_stage_lo_q}; // R8 R9
    end else if (calc_done) begin
      ovf_cnt_q <= ovf_cnt_q + div_dvd_q[19:0]; // R20
    end else if (ovf_hit) begin
      ovf_cnt_q <= ovf_cnt_q + 20'h00001; // R6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ovf_stage_lo_q <= 8'h00;
      ovf_stage_mid_q <= 8'h00;
      ovf_rd_mid_q <= 8'h00;
      ovf_rd_hi_q <= 4'h0;
    end else begin
      if (wr_at(bus_req, `MTC_ADDR_OVF_LO)) begin
        ovf_stage_lo_q <= bus_req.wdata; // R9
      end
      if (wr_at(bus_req, `MTC_ADDR_OVF_MID)) begin
        ovf_stage_mid_q <= bus_req.wdata; // R9
      end
      if (bus_req.rd && (bus_req.addr == `MTC_ADDR_OVF_LO)) begin
        ovf_rd_mid_q <= ovf_cnt_q[15:8]; // R7
        ovf_rd_hi_q <= ovf_cnt_q[19:16]; // R7
      end
    end
  end

  // ==========================================================
  // Capture on SFD
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      capture_q <= 16'h0000;
      ovf_cap_q <= 20'h00000;
    end else if (sfd_rise) begin
      capture_q <= timer_q; // R5
      ovf_cap_q <= ovf_cnt_q; // R5
    end
  end

  // ==========================================================
  // Software configuration
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sel_lo_q <= 1'b0;
      sync_en_q <= `MTC_SYNC_RST;
      cmp_val_q <= 8'h00;
      period_q <= `MTC_PERIOD_RST;
      ovf_cmp_q <= 20'h00000;
      mask_q <= '0;
    end else begin
      if (cfg_wr) begin
        sel_lo_q <= bus_req.wdata[`MTC_CFG_BYTE_SEL]; // R2
        sync_en_q <= bus_req.wdata[`MTC_CFG_SYNC];
      end
      if (wr_at(bus_req, `MTC_ADDR_BYTE_CMP)) begin
        cmp_val_q <= bus_req.wdata;
      end
      if (wr_at(bus_req, `MTC_ADDR_CAP_LO)) begin
        period_q[7:0] <= bus_req.wdata;
      end
      if (wr_at(bus_req, `MTC_ADDR_CAP_HI)) begin
        period_q[15:8] <= bus_req.wdata;
      end
      if (wr_at(bus_req, `MTC_ADDR_OCC0)) begin
        ovf_cmp_q[7:0] <= bus_req.wdata;
      end
      if (wr_at(bus_req, `MTC_ADDR_OCC1)) begin
        ovf_cmp_q[15:8] <= bus_req.wdata;
      end
      if (wr_at(bus_req, `MTC_ADDR_OCC2)) begin
        ovf_cmp_q[19:16] <= bus_req.wdata[3:0];
        mask_q.cmp <= bus_req.wdata[`MTC_OCC2_CMP_MASK];
        mask_q.ovf <= bus_req.wdata[`MTC_OCC2_OVF_MASK];
        mask_q.ovf_match <= bus_req.wdata[`MTC_OCC2_MATCH_MASK];
      end
    end
  end

  // ==========================================================
  // Event flags: write 0 clears, write 1 keeps, a new event wins
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flag_q <= '0;
    end else begin
      flag_q.cmp <= (flag_q.cmp && !(cfg_wr && !bus_req.wdata[`MTC_CFG_CMP_FLAG])) || ev.cmp; // R3 R12
      flag_q.ovf <= (flag_q.ovf && !(cfg_wr && !bus_req.wdata[`MTC_CFG_OVF_FLAG])) || ev.ovf; // R12
      flag_q.ovf_match <= (flag_q.ovf_match && !(cfg_wr && !bus_req.wdata[`MTC_CFG_MATCH_FLAG]))
                          || ev.ovf_match; // R11 R12
    end
  end

  // ==========================================================
  // Outputs
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_req <= '0;
      dma_trig_compare <= 1'b0;
      dma_trig_overflow <= 1'b0;
      timer_running <= 1'b0;
    end else begin
      irq_req <= ev & mask_q; // R3 R11
      dma_trig_compare <= ev.cmp; // R13
      dma_trig_overflow <= ev.ovf; // R13
      timer_running <= counting;
    end
  end

  // Read data, valid in the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else if (!bus_req.rd) begin
      rd_data <= 8'h00;
    end else begin
      case (bus_req.addr)
        `MTC_ADDR_CFG: rd_data <= {flag_q.cmp, flag_q.ovf, flag_q.ovf_match, 1'b0, sel_lo_q, 1'b0,
                                   sync_en_q, counting}; // R25
        `MTC_ADDR_CNT_LO: rd_data <= pick_byte(timer_q, 1'b1);
        `MTC_ADDR_CNT_HI: rd_data <= pick_byte(timer_q, 1'b0);
        `MTC_ADDR_BYTE_CMP: rd_data <= cmp_val_q;
        `MTC_ADDR_OVF_LO: rd_data <= ovf_cnt_q[7:0];
        `MTC_ADDR_OVF_MID: rd_data <= ovf_rd_mid_q; // R7
        `MTC_ADDR_OVF_HI: rd_data <= {4'h0, ovf_rd_hi_q}; // R7
        `MTC_ADDR_CAP_LO: rd_data <= pick_byte(capture_q, 1'b1);
        `MTC_ADDR_CAP_HI: rd_data <= pick_byte(capture_q, 1'b0);
        `MTC_ADDR_OCC0: rd_data <= ovf_cap_q[7:0];
        `MTC_ADDR_OCC1: rd_data <= ovf_cap_q[15:8];
        `MTC_ADDR_OCC2: rd_data <= {mask_q.cmp, mask_q.ovf, mask_q.ovf_match, 1'b0, ovf_cap_q[19:16]};
        default: rd_data <= 8'h00;
      endcase
    end
  end

endmodule : mtc_mac_timer

`default_nettype wire

// >>> inc/mtc_regs.svh
// MAC timer compare/capture/sync block: register offsets, field positions,
// reset values and timing counts. Definitions only.
// Assumes an 8-bit register port with a 4-bit address.
`ifndef MTC_REGS_SVH
`define MTC_REGS_SVH

// ==========================================================
// Register offsets
`define MTC_ADDR_CFG 4'h0
`define MTC_ADDR_CNT_LO 4'h1
`define MTC_ADDR_CNT_HI 4'h2
`define MTC_ADDR_BYTE_CMP 4'h3
`define MTC_ADDR_OVF_LO 4'h4
`define MTC_ADDR_OVF_MID 4'h5
`define MTC_ADDR_OVF_HI 4'h6
`define MTC_ADDR_CAP_LO 4'h7
`define MTC_ADDR_CAP_HI 4'h8
`define MTC_ADDR_OCC0 4'h9
`define MTC_ADDR_OCC1 4'hA
`define MTC_ADDR_OCC2 4'hB

// ==========================================================
// Field positions
`define MTC_CFG_CMP_FLAG 7
`define MTC_CFG_OVF_FLAG 6
`define MTC_CFG_MATCH_FLAG 5
`define MTC_CFG_BYTE_SEL 3
`define MTC_CFG_SYNC 1
`define MTC_CFG_RUN 0
`define MTC_OCC2_CMP_MASK 7
`define MTC_OCC2_OVF_MASK 6
`define MTC_OCC2_MATCH_MASK 5

// ==========================================================
// Reset values
`define MTC_SYNC_RST 1'b1
`define MTC_PERIOD_RST 16'hFFFF

// ==========================================================
// Timing and resync arithmetic
`define MTC_SYNC_OVERHEAD 7'd75
`define MTC_RATIO_NUM 40'd15625
`define MTC_RATIO_SHIFT 4
`define MTC_ROUND_HALF 40'd8
`define MTC_SLEEP_WRAP 25'h1000000
`define MTC_DIV_STEPS 6'd40

`endif

// >>> inc/mtc_pkg.sv
// Types shared by the MAC timer compare/capture/sync block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mtc_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START_WAIT,
    ST_CALC,
    ST_RUN,
    ST_STOP_WAIT
  } mtc_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mtc_bus_req_t;

  typedef struct packed {
    logic cmp;
    logic ovf;
    logic ovf_match;
  } mtc_event_t;

endpackage : mtc_pkg

`default_nettype wire

// >>> tb/mtc_mac_timer_assertions.sv
// Checker for the MAC timer block, watching only its top-level ports.
// Assumes mtc_pkg and mtc_regs.svh are compiled or included first.
`include "mtc_regs.svh"
`default_nettype none

module mtc_mac_timer_assertions (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire mtc_pkg::mtc_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  input wire mtc_pkg::mtc_event_t irq_req,
  input wire logic dma_trig_compare,
  input wire logic dma_trig_overflow,
  input wire logic timer_running
);
  import mtc_pkg::*;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Configuration writes
  sequence s_cfg_wr(logic [7:0] v);
    bus_req.wr && bus_req.addr == `MTC_ADDR_CFG && bus_req.wdata == v;
  endsequence

  // ==========================================================
  // Pulses and events
  property p_dma_cmp_pulse;
    dma_trig_compare |=> !dma_trig_compare;
  endproperty
  a_dma_cmp_pulse: assert property (p_dma_cmp_pulse) else $error("compare trigger longer than one cycle");

  property p_dma_ovf_pulse;
    dma_trig_overflow |=> !dma_trig_overflow;
  endproperty
  a_dma_ovf_pulse: assert property (p_dma_ovf_pulse) else $error("overflow trigger longer than one cycle");

  property p_match_pulse;
    irq_req.ovf_match |=> !irq_req.ovf_match;
  endproperty
  a_match_pulse: assert property (p_match_pulse) else $error("match request longer than one cycle");

  property p_cmp_irq_dma;
    irq_req.cmp |-> dma_trig_compare;
  endproperty
  a_cmp_irq_dma: assert property (p_cmp_irq_dma) else $error("compare request without compare event");

  property p_ovf_irq_dma;
    irq_req.ovf |-> dma_trig_overflow;
  endproperty
  a_ovf_irq_dma: assert property (p_ovf_irq_dma) else $error("overflow request without overflow event");

  // ==========================================================
  // Start, stop and read data
  property p_sync_start_wait;
    s_cfg_wr(8'h03) ##0 !timer_running |=> !timer_running [*2];
  endproperty
  a_sync_start_wait: assert property (p_sync_start_wait) else $error("sync start ran at write");

  property p_sync_stop_hold;
    s_cfg_wr(8'h02) ##0 timer_running |=> timer_running [*2];
  endproperty
  a_sync_stop_hold: assert property (p_sync_stop_hold) else $error("sync stop halted at write");

  property p_imm_start;
    s_cfg_wr(8'h01) ##0 !timer_running |-> ##[1:2] timer_running;
  endproperty
  a_imm_start: assert property (p_imm_start) else $error("immediate start late");

  property p_rd_quiet;
    rd_data != 8'h00 |-> $past(bus_req.rd);
  endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside read slot");
endmodule : mtc_mac_timer_assertions

bind mtc_mac_timer mtc_mac_timer_assertions mtc_mac_timer_assertions_i (
  .sys_clk, .nrst, .bus_req, .rd_data, .irq_req, .dma_trig_compare, .dma_trig_overflow, .timer_running
);

`default_nettype wire

// >>> tb/mtc_sleep_radio_model.sv
// Far-side model: radio SFD status and a free-running sleep timer.
// Assumes the bench supplies the system clock and an SFD request level.
`default_nettype none

module mtc_sleep_radio_model #(
  parameter real HALF_NS = 2441.40625
) (
  input wire logic sys_clk,
  input wire logic sfd_go,
  output logic sfd_status,
  output logic sleep_clk,
  output logic [23:0] sleep_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Sleep clock, free running, unrelated to sys_clk
  initial begin
    sleep_clk = 1'b0;
    sleep_count = 24'h000100;
    forever begin
      #(HALF_NS) sleep_clk = ~sleep_clk;
      if (sleep_clk) sleep_count = sleep_count + 24'h000001;
    end
  end

  // ==========================================================
  // SFD status follows the request level
  initial sfd_status = 1'b0;
  always @(posedge sys_clk) sfd_status <= sfd_go;
endmodule : mtc_sleep_radio_model

`default_nettype wire

// >>> tb/mtc_mac_timer_tb.sv
// Self-checking bench for the MAC timer block.
// Assumes mtc_pkg, the checker and the far-side model are compiled first.
`default_nettype none

module mtc_mac_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mtc_pkg::*;

  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic sfd_go = 1'b0;
  mtc_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  mtc_event_t irq_req;
  logic dma_trig_compare, dma_trig_overflow, timer_running, sfd_status, sleep_clk;
  logic [23:0] sleep_count;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int cnt [5] = '{0, 0, 0, 0, 0};

  mtc_mac_timer mtc_mac_timer_i (.sys_clk, .nrst, .bus_req, .rd_data, .sfd_status, .sleep_clk, .sleep_count,
    .irq_req, .dma_trig_compare, .dma_trig_overflow, .timer_running);
  mtc_sleep_radio_model mtc_sleep_radio_model_i (.sys_clk, .sfd_go, .sfd_status, .sleep_clk, .sleep_count);

  // ==========================================================
  // Clock, pulse counters, timeout
  initial forever #2.5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    cnt[0] <= cnt[0] + dma_trig_compare;
    cnt[1] <= cnt[1] + dma_trig_overflow;
    cnt[2] <= cnt[2] + irq_req.cmp;
    cnt[3] <= cnt[3] + irq_req.ovf;
    cnt[4] <= cnt[4] + irq_req.ovf_match;
    if (cyc == 40000) begin
      $display("Error at %0t: timeout", $time);
      n_errors++;
      end_sim();
    end
  end

  // ==========================================================
  // Bus and check tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk) bus_req <= '0;
    #1 d = rd_data;
  endtask : rd

  task automatic rd_pair(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask : rd_pair

  // Low byte first so the upper bytes are latched
  task automatic rd_tri(input logic [3:0] a, output logic [19:0] v);
    logic [7:0] b;
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
    rd(a + 4'h2, b);
    v[19:16] = b[3:0];
  endtask : rd_tri

  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    comparisons++;
    if (g !== e) begin
      $display("Error at %0t: got %h, expected %h", $time, g, e);
      n_errors++;
    end
  endtask : chk

  task automatic wait_run(input logic v);
    for (int i = 0; i < 7000 && timer_running !== v; i++) @(posedge sys_clk) #1;
    chk(timer_running, v);
  endtask : wait_run

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] b;
    rd(4'h0, b);
    chk(b, 8'h22);
    rd(4'hC, b);
    chk(b, 8'h00);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_count_cmp;
    logic [7:0] b;
    logic [19:0] v;
    int base [5];
    wr(4'h7, 8'h10);
    wr(4'h8, 8'h00);
    wr(4'h4, 8'h34);
    wr(4'h5, 8'h12);
    wr(4'h6, 8'h05);
    rd_tri(4'h4, v);
    chk(v, 20'h51234);
    wr(4'h4, 8'h00);
    wr(4'h5, 8'h00);
    rd_tri(4'h4, v);
    chk(v, 20'h51234);
    wr(4'h6, 8'h00);
    rd_tri(4'h4, v);
    chk(v, 20'h00000);
    wr(4'h9, 8'h03);
    wr(4'hA, 8'h00);
    wr(4'hB, 8'hA0);
    wr(4'h3, 8'h08);
    base = cnt;
    wr(4'h0, 8'h09);
    repeat (160) @(posedge sys_clk);
    // Stop with ones in the flag bits so the flags survive
    wr(4'h0, 8'hE8);
    repeat (2) @(posedge sys_clk);
    rd_tri(4'h4, v);
    chk(v, cnt[1] - base[1]);
    chk(cnt[1] - base[1] inside {[9:11]}, 1'b1);
    chk(cnt[0] - base[0] - cnt[1] + base[1] inside {[-1:1]}, 1'b1);
    chk(cnt[2] - base[2], cnt[0] - base[0]);
    chk(cnt[3] - base[3], 0);
    chk(cnt[4] - base[4], 1);
    rd(4'h0, b);
    chk(b & 8'hE0, 8'hE0);
    wr(4'h0, 8'hE8);
    rd(4'h0, b);
    chk(b, 8'hE8);
    wr(4'h0, 8'h08);
    rd(4'h0, b);
    chk(b, 8'h08);
    $display("t_count_cmp done");
  endtask : t_count_cmp

  task automatic t_sel_hi;
    int base [5];
    wr(4'hB, 8'h40);
    base = cnt;
    wr(4'h0, 8'h01);
    repeat (160) @(posedge sys_clk);
    wr(4'h0, 8'h00);
    repeat (2) @(posedge sys_clk);
    chk(cnt[0] - base[0], 0);
    chk(cnt[1] - base[1] > 8, 1'b1);
    chk(cnt[3] - base[3], cnt[1] - base[1]);
    $display("t_sel_hi done");
  endtask : t_sel_hi

  task automatic t_capture;
    logic [15:0] t, c;
    logic [19:0] v, vc;
    rd_pair(4'h1, t);
    rd_tri(4'h4, v);
    @(posedge sys_clk) sfd_go <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sfd_go <= 1'b0;
    rd_pair(4'h7, c);
    chk(c, t);
    rd_tri(4'h9, vc);
    chk(vc, v);
    $display("t_capture done");
  endtask : t_capture

  task automatic t_sync;
    logic [19:0] o, o2;
    logic [15:0] t, t2;
    logic [23:0] ns;
    longint nd, c, d;
    wr(4'h7, 8'hE8);
    wr(4'h8, 8'h03);
    wr(4'h0, 8'h03);
    wait_run(1'b1);
    wr(4'h0, 8'h02);
    wait_run(1'b0);
    ns = sleep_count;
    rd_tri(4'h4, o);
    rd_pair(4'h1, t);
    wr(4'h0, 8'h03);
    wait_run(1'b1);
    nd = longint'(sleep_count - ns);
    // Immediate stop freezes the reloaded values for reading
    wr(4'h0, 8'h00);
    rd_tri(4'h4, o2);
    rd_pair(4'h1, t2);
    if (nd == 0) nd = 64'd16777216;
    c = (nd * 15625 + 8) / 16 + t + 75;
    d = longint'(o2) * 1000 + t2 - (longint'(o) * 1000 + c);
    chk(d inside {[-1:20]}, 1'b1);
    $display("t_sync done");
  endtask : t_sync

  // ==========================================================
  // Main sequence and verdict
  task automatic end_sim;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset();
    t_count_cmp();
    t_sel_hi();
    t_capture();
    t_sync();
    end_sim();
  end
endmodule : mtc_mac_timer_tb

`default_nettype wire
